// ### pkg/rsc_params.svh
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ------------------------------------------------------------
// Store geometry
// ------------------------------------------------------------
`define RSC_DATA_W        32
`define RSC_DEPTH         512
`define RSC_PTR_W         9
`define RSC_CNT_W         10
`define RSC_WRAP_SIZE     10'h000
`define RSC_PTR_ZERO      9'h000
`define RSC_CNT_ONE       10'h001

// ------------------------------------------------------------
// Trigger and interval
// ------------------------------------------------------------
`define RSC_TRIG_W        4
`define RSC_TRIG_ONESHOT  0
`define RSC_IVL_W         20
`define RSC_DEF_IVL_MS    20'h000AF
`define RSC_CLK_MHZ       100
`define RSC_TICK_US       1000
`define RSC_TICK_CYCLES   (`RSC_TICK_US * `RSC_CLK_MHZ)
`define RSC_DIV_W         17

`endif

// ### pkg/rsc_pkg.sv
package rsc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_REPEAT,
		ST_ONESHOT,
		ST_DONE
	} rsc_state_e;
endpackage

// ### pkg/rsc_buf_if.sv
`include "rsc_params.svh"

interface rsc_buf_if;
	logic                   in_valid;
	logic                   in_ready;
	logic [`RSC_DATA_W-1:0] in_data;
	logic                   out_valid;
	logic                   out_ready;
	logic [`RSC_DATA_W-1:0] out_data;

	modport fill (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	modport skid (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface

// ### logic/rsc_skid.sv
`include "rsc_params.svh"

module rsc_skid (
	input wire logic clk,
	input wire logic rst,
	rsc_buf_if.skid  bus
);
	// ------------------------------------------------------------
	// Two-entry buffer; head always in slot 0
	// ------------------------------------------------------------
	logic [`RSC_DATA_W-1:0] slot0_reg;
	logic [`RSC_DATA_W-1:0] slot1_reg;
	logic [1:0]             fill_reg;
	logic                   valid_reg;
	wire                    push = bus.in_valid && bus.in_ready;
	wire                    pop  = bus.out_valid && bus.out_ready;
	wire [1:0]              fill_next = fill_reg + {1'b0, push} - {1'b0, pop};

	// Valid has its own flop so the top output leaves from a register
	assign bus.in_ready  = (fill_reg != 2'h2);
	assign bus.out_valid = valid_reg;
	assign bus.out_data  = slot0_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fill_reg  <= 2'h0;
			valid_reg <= 1'b0;
			slot0_reg <= '0;
			slot1_reg <= '0;
		end else begin
			fill_reg  <= fill_next;
			valid_reg <= (fill_next != 2'h0);
			if (pop) begin
				slot0_reg <= (fill_reg == 2'h2) ? slot1_reg : bus.in_data;
			end else if (push && fill_reg == 2'h0) begin
				slot0_reg <= bus.in_data;
			end
			if (push && ((fill_reg == 2'h1 && !pop) || fill_reg == 2'h2)) begin
				slot1_reg <= bus.in_data;
			end
		end
	end
endmodule

// ### logic/rsc_store.sv
// Notes on behaviour
// (R1) Arm waits for trigger before storing
// (R2) Size 1..512 fixed; zero means wrap-around
// (R3) Wrap mode overwrites from first location
// (R4) Fixed mode halts at programmed count, full
// (R5) Interval pacing only in even trigger modes
// (R6) Odd trigger modes: one reading per trigger
// (R7) Repeat rate follows current interval setting
// (R8) Waiting indication shown until first trigger
// (R9) Trigger, delay or interval change stops storage
// (R10) Re-arm aborts sequence and arms again
// (R11) Stored readings recallable during and after storage
// (R12) Controller stops wrap storage before reading
// (R13) Clear or power-up restores saved size option
// (R14) Full flag set at size, cleared on arm
// (R15) Half flag set at half, cleared on arm
// (R16) Interval zero means 175 ms
// (R17) Arm clears pointer, count and running sequence
`include "rsc_params.svh"

module rsc_store
	import rsc_pkg::*;
#(
	parameter int TICK_CYCLES = `RSC_TICK_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   dev_clear,
	input  wire logic [`RSC_CNT_W-1:0]  saved_size,
	input  wire logic                   cmd_arm,
	input  wire logic [`RSC_CNT_W-1:0]  cmd_size,
	input  wire logic                   cmd_trig_change,
	input  wire logic [`RSC_TRIG_W-1:0] trig_mode,
	input  wire logic [`RSC_IVL_W-1:0]  interval_ms,
	input  wire logic                   trig_pulse,
	input  wire logic                   reading_valid,
	input  wire logic [`RSC_DATA_W-1:0] reading_data,
	input  wire logic                   recall_start,
	output logic                        recall_valid,
	input  wire logic                   recall_ready,
	output logic [`RSC_DATA_W-1:0]      recall_data,
	output logic                        waiting_ind,
	output logic                        storing,
	output logic                        store_full,
	output logic                        store_half,
	output logic [`RSC_CNT_W-1:0]       stored_count,
	output logic                        wrap_mode
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [`RSC_PTR_W-1:0] ptr_inc(input logic [`RSC_PTR_W-1:0] p);
		ptr_inc = p + 9'h001;
	endfunction

	// ------------------------------------------------------------
	// State and storage
	// ------------------------------------------------------------
	rsc_state_e                 state_reg;
	rsc_state_e                 state_next;
	logic [`RSC_DATA_W-1:0]     mem [`RSC_DEPTH];
	logic [`RSC_DATA_W-1:0]     rdg_reg;
	logic [`RSC_CNT_W-1:0]      size_reg;
	logic                       wrap_reg;
	logic [`RSC_PTR_W-1:0]      wr_ptr_reg;
	logic [`RSC_CNT_W-1:0]      count_reg;
	logic                       full_reg;
	logic                       half_reg;
	logic [`RSC_DIV_W-1:0]      div_reg;
	logic [`RSC_IVL_W-1:0]      ivl_cnt_reg;
	logic [`RSC_PTR_W-1:0]      rd_ptr_reg;
	logic [`RSC_CNT_W-1:0]      rd_left_reg;
	rsc_buf_if                  buf_bus ();

	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	wire                    repeat_mode = !trig_mode[`RSC_TRIG_ONESHOT]; // R5 R6
	wire [`RSC_IVL_W-1:0]   ivl_eff     = (interval_ms == '0) ?
		`RSC_DEF_IVL_MS : interval_ms; // R16
	wire                    ms_tick     = (div_reg == `RSC_DIV_W'(TICK_CYCLES - 1));
	wire                    ivl_done    = ms_tick && (ivl_cnt_reg + 20'h00001 >= ivl_eff); // R7
	wire                    in_wait     = (state_reg == ST_WAIT);
	wire                    in_repeat   = (state_reg == ST_REPEAT);
	wire                    in_oneshot  = (state_reg == ST_ONESHOT);
	wire                    abort       = cmd_trig_change || dev_clear || cmd_arm;
	wire                    store_evt   = !abort &&
		((in_wait && trig_pulse) || // R1
		 (in_repeat && ivl_done) ||  // R5 R7
		 (in_oneshot && trig_pulse)); // R6
	wire [`RSC_CNT_W-1:0]   count_inc   = count_reg + `RSC_CNT_ONE;
	wire                    at_depth    = (count_reg == `RSC_CNT_W'(`RSC_DEPTH));
	wire                    reach_full  = !wrap_reg && (count_inc == size_reg); // R4
	wire                    reach_half  = !wrap_reg &&
		({count_inc, 1'b0} >= {1'b0, size_reg}); // R15
	wire                    recall_ok   = !(wrap_reg && (in_repeat || in_oneshot)); // R12
	wire                    rd_take     = buf_bus.in_valid && buf_bus.in_ready;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				state_next = ST_IDLE;
			end
			ST_WAIT: begin
				if (trig_pulse) begin
					if (reach_full) begin
						state_next = ST_DONE;
					end else if (repeat_mode) begin
						state_next = ST_REPEAT; // R5
					end else begin
						state_next = ST_ONESHOT; // R6
					end
				end
			end
			ST_REPEAT: begin
				if (ivl_done && reach_full) begin
					state_next = ST_DONE; // R4
				end
			end
			ST_ONESHOT: begin
				if (trig_pulse && reach_full) begin
					state_next = ST_DONE; // R4
				end
			end
			ST_DONE: begin
				state_next = ST_DONE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (cmd_trig_change) begin
			state_next = ST_IDLE; // R9
		end
		if (cmd_arm) begin
			state_next = ST_WAIT; // R10
		end
		if (dev_clear) begin
			state_next = ST_IDLE; // R13
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Size option; reset takes zero, saved option loaded after release
	// ------------------------------------------------------------
	logic boot_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			size_reg <= `RSC_WRAP_SIZE;
			wrap_reg <= 1'b1;
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
			if (boot_reg || dev_clear) begin
				size_reg <= saved_size; // R13
				wrap_reg <= (saved_size == `RSC_WRAP_SIZE);
			end else if (cmd_arm) begin
				size_reg <= cmd_size; // R2
				wrap_reg <= (cmd_size == `RSC_WRAP_SIZE); // R2
			end
		end
	end

	// ------------------------------------------------------------
	// Latest reading and write side
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdg_reg <= '0;
		end else if (reading_valid) begin
			rdg_reg <= reading_data;
		end
	end

	always_ff @(posedge clk) begin
		if (store_evt) begin
			mem[wr_ptr_reg] <= rdg_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= `RSC_PTR_ZERO;
			count_reg  <= '0;
		end else if (cmd_arm || dev_clear) begin
			wr_ptr_reg <= `RSC_PTR_ZERO; // R17
			count_reg  <= '0; // R17
		end else if (store_evt) begin
			wr_ptr_reg <= ptr_inc(wr_ptr_reg); // R3
			if (!at_depth) begin
				count_reg <= count_inc;
			end
		end
	end

	// Arm clears; a store in the arm cycle is already suppressed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			full_reg <= 1'b0;
			half_reg <= 1'b0;
		end else if (cmd_arm || dev_clear) begin
			full_reg <= 1'b0; // R14
			half_reg <= 1'b0; // R15
		end else if (store_evt) begin
			if (reach_full) begin
				full_reg <= 1'b1; // R14
			end
			if (reach_half) begin
				half_reg <= 1'b1; // R15
			end
		end
	end

	// ------------------------------------------------------------
	// Interval pacing; divider restarts at each store for exact spacing
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg     <= '0;
			ivl_cnt_reg <= '0;
		end else if (store_evt || !in_repeat) begin
			div_reg     <= '0;
			ivl_cnt_reg <= '0;
		end else if (ms_tick) begin
			div_reg     <= '0;
			ivl_cnt_reg <= ivl_cnt_reg + 20'h00001; // R7
		end else begin
			div_reg <= div_reg + `RSC_DIV_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Recall path; a stalled reader holds words in the buffer
	// ------------------------------------------------------------
	assign buf_bus.in_valid  = (rd_left_reg != '0) && recall_ok; // R11 R12
	assign buf_bus.in_data   = mem[rd_ptr_reg];
	assign buf_bus.out_ready = recall_ready;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_ptr_reg  <= `RSC_PTR_ZERO;
			rd_left_reg <= '0;
		end else if (recall_start) begin
			rd_ptr_reg  <= (wrap_reg && at_depth) ? wr_ptr_reg : `RSC_PTR_ZERO; // R11
			rd_left_reg <= count_reg; // R11
		end else if (rd_take) begin
			rd_ptr_reg  <= ptr_inc(rd_ptr_reg);
			rd_left_reg <= rd_left_reg - `RSC_CNT_ONE;
		end
	end

	rsc_skid u_skid (
		.clk (clk),
		.rst (rst),
		.bus (buf_bus)
	);

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waiting_ind  <= 1'b0;
			storing      <= 1'b0;
			store_full   <= 1'b0;
			store_half   <= 1'b0;
			stored_count <= '0;
			wrap_mode    <= 1'b1;
		end else begin
			waiting_ind  <= (state_next == ST_WAIT); // R8
			storing      <= (state_next == ST_REPEAT) || (state_next == ST_ONESHOT);
			store_full   <= full_reg;
			store_half   <= half_reg;
			stored_count <= count_reg;
			wrap_mode    <= wrap_reg;
		end
	end

	assign recall_valid = buf_bus.out_valid;
	assign recall_data  = buf_bus.out_data;
endmodule

// ### dv/rsc_store_sva.sv
`include "rsc_params.svh"

module rsc_store_sva (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  dev_clear,
	input wire logic                  cmd_arm,
	input wire logic [`RSC_CNT_W-1:0] cmd_size,
	input wire logic                  cmd_trig_change,
	input wire logic                  recall_valid,
	input wire logic                  recall_ready,
	input wire logic [`RSC_DATA_W-1:0] recall_data,
	input wire logic                  waiting_ind,
	input wire logic                  storing,
	input wire logic                  store_full,
	input wire logic                  store_half,
	input wire logic [`RSC_CNT_W-1:0] stored_count,
	input wire logic                  wrap_mode
);
	logic [`RSC_CNT_W-1:0] size_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Size of the latest arm, to judge full and half
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			size_reg <= `RSC_WRAP_SIZE;
		else if (cmd_arm)
			size_reg <= cmd_size;
	end

	a_count_max: assert property (stored_count <= 10'h200)
		else $error("count above depth");
	a_wait_excl: assert property (waiting_ind |-> !storing)
		else $error("waiting while storing");
	a_arm_waits: assert property (cmd_arm && !dev_clear |-> ##[1:2] waiting_ind)
		else $error("arm shows no wait");
	a_full_fixed: assert property (store_full |-> !wrap_mode)
		else $error("full in wrap mode");
	a_full_stops: assert property ($rose(store_full) |-> !storing && stored_count == size_reg)
		else $error("full at wrong count");
	a_half_at: assert property ($rose(store_half) |-> {stored_count, 1'b0} >= {1'b0, size_reg})
		else $error("half flag early");
	a_arm_clears: assert property (cmd_arm && !dev_clear |-> ##[1:3] !store_full && !store_half)
		else $error("arm kept flags");
	a_change_stop: assert property (cmd_trig_change && !cmd_arm && !dev_clear |-> ##[1:2] !storing)
		else $error("change left storage on");
	a_recall_hold: assert property (recall_valid && !recall_ready && !dev_clear
		|=> recall_valid && $stable(recall_data))
		else $error("recall word dropped");
endmodule

bind rsc_store rsc_store_sva u_sva (.clk, .rst, .dev_clear, .cmd_arm, .cmd_size, .cmd_trig_change,
	.recall_valid, .recall_ready, .recall_data, .waiting_ind, .storing, .store_full, .store_half,
	.stored_count, .wrap_mode);

// ### dv/rsc_sink.sv
module rsc_sink (
	input wire logic clk,
	input wire logic rst,
	output logic     ready
);
	timeunit 1ns;
	timeprecision 100ps;
	int seed = 32'h006C3C7F;

	// Stalls at random so held words are exercised
	initial ready = 1'b0;
	always @(negedge clk) ready <= !rst && ($random(seed) % 4 != 0);
endmodule

// ### dv/rsc_store_test.sv
`include "rsc_params.svh"

module rsc_store_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, dev_clear, cmd_arm, cmd_trig_change, trig_pulse, reading_valid, recall_start;
	logic recall_valid, recall_ready, waiting_ind, storing, store_full, store_half, wrap_mode;
	logic [`RSC_CNT_W-1:0]  saved_size, cmd_size, stored_count;
	logic [`RSC_TRIG_W-1:0] trig_mode;
	logic [`RSC_IVL_W-1:0]  interval_ms;
	logic [`RSC_DATA_W-1:0] reading_data, recall_data;
	logic [`RSC_DATA_W-1:0] hist[$], exp_q[$];
	int                     n_errors, checks_done, seed, c;
	wire logic [9:0] st = {5'h00, wrap_mode, waiting_ind, storing, store_full, store_half};

	rsc_store #(.TICK_CYCLES(4)) DUT (.*);
	rsc_sink u_sink (.clk(clk), .rst(rst), .ready(recall_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic fail(input string m);
		$display("[ERR] %0t %s", $time, m);
		n_errors++;
	endtask
	task automatic chk_stat(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) fail($sformatf("status %h want %h", got, exp));
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) fail($sformatf("word %h want %h", got, exp));
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic store();
		reading_data = $random(seed);
		reading_valid = 1'b1;
		step(1);
		reading_valid = 1'b0;
		pulse(trig_pulse);
		step(2);
		hist.push_back(reading_data);
	endtask
	task automatic arm(input logic [9:0] sz);
		cmd_size = sz;
		pulse(cmd_arm);
		step(2);
		hist.delete();
	endtask
	task automatic wait_cnt(input logic [9:0] n);
		c = 0;
		while (stored_count !== n && c < 20000) begin
			step(1);
			c++;
		end
		if (c >= 20000) begin
			fail("count wait ran out");
			finish_test();
		end
	endtask
	task automatic recall(input int n);
		int k;
		for (int i = hist.size() - n; i < hist.size(); i++) exp_q.push_back(hist[i]);
		pulse(recall_start);
		while (exp_q.size() != 0 && k < 20000) begin
			step(1);
			k++;
		end
		if (k >= 20000) begin
			fail("recall wait ran out");
			finish_test();
		end
	endtask

	// Oldest note is matched against each accepted word
	always @(posedge clk) begin
		if (recall_valid === 1'b1 && recall_ready === 1'b1) begin
			if (exp_q.size() == 0)
				fail("unexpected word");
			else
				chk_word(recall_data, exp_q.pop_front());
		end
	end

	initial begin
		seed = 32'h006C3C7F;
		{rst, dev_clear, cmd_arm, cmd_trig_change, trig_pulse, reading_valid, recall_start} = 7'h40;
		saved_size = 10'h000;
		cmd_size = 10'h000;
		trig_mode = 4'h1;
		interval_ms = 20'h00001;
		reading_data = 32'h00000000;
		step(16);
		rst = 1'b0;
		step(3);
		chk_stat(st, 10'h010);
		arm(10'h003);
		chk_stat(st, 10'h008);
		store();
		chk_stat(stored_count, 10'h001);
		store();
		chk_stat(st, 10'h005);
		store();
		pulse(trig_pulse);
		step(2);
		chk_stat(st, 10'h003);
		chk_stat(stored_count, 10'h003);
		recall(3);
		// Trigger codes 0 to 9: repeating even codes fill size 2, one-shot odd codes store once
		for (int m = 0; m < 10; m++) begin
			trig_mode = 4'(m);
			arm(10'h002);
			pulse(trig_pulse);
			step(12);
			chk_stat(stored_count, m[0] ? 10'h001 : 10'h002);
		end
		trig_mode = 4'h2;
		arm(10'h004);
		chk_stat(st, 10'h008);
		chk_stat(stored_count, 10'h000);
		pulse(trig_pulse);
		wait_cnt(10'h001);
		wait_cnt(10'h004);
		chk_stat(10'(c), 10'h00C);
		chk_stat(st, 10'h003);
		interval_ms = 20'h00000;
		arm(10'h002);
		pulse(trig_pulse);
		wait_cnt(10'h001);
		wait_cnt(10'h002);
		chk_stat(10'(c), 10'h2BC);
		interval_ms = 20'h00001;
		arm(10'h008);
		pulse(trig_pulse);
		wait_cnt(10'h002);
		pulse(cmd_trig_change);
		step(12);
		chk_stat(st, 10'h000);
		chk_stat(stored_count, 10'h002);
		trig_mode = 4'h1;
		arm(10'h000);
		repeat (513) store();
		chk_stat(stored_count, 10'h200);
		chk_stat(st[4:3], 2'h2);
		pulse(cmd_trig_change);
		step(2);
		recall(512);
		saved_size = 10'h005;
		pulse(dev_clear);
		step(3);
		chk_stat(st, 10'h000);
		chk_stat(stored_count, 10'h000);
		finish_test();
	end
endmodule
